//--- hdl/scm_pkg.sv
`default_nettype none
package scm_pkg;
    localparam int unsigned AW = 7;
    localparam logic [AW-1:0] OFF_MAX_CYC   = 7'h00;
    localparam logic [AW-1:0] OFF_CALC_COPY = 7'h04;
    localparam logic [AW-1:0] OFF_MIN_DLY   = 7'h08;
    localparam logic [AW-1:0] OFF_CMD       = 7'h0c;
    localparam logic [AW-1:0] OFF_OUT_DLY   = 7'h10;
    localparam logic [AW-1:0] OFF_MISSED    = 7'h14;
    localparam logic [AW-1:0] OFF_OVERRUN   = 7'h18;
    localparam logic [AW-1:0] OFF_SHORT     = 7'h1c;
    localparam logic [AW-1:0] OFF_MIN_CD    = 7'h20;
    localparam logic [AW-1:0] OFF_MAX_CD    = 7'h24;
    localparam logic [AW-1:0] OFF_MIN_SD    = 7'h28;
    localparam logic [AW-1:0] OFF_MAX_SD    = 7'h2c;
    localparam logic [AW-1:0] OFF_APP_OV    = 7'h30;
    localparam logic [AW-1:0] OFF_FRAME_REP = 7'h34;
    localparam logic [AW-1:0] OFF_LATE      = 7'h38;
    localparam logic [AW-1:0] OFF_MODE      = 7'h3c;
    localparam logic [AW-1:0] OFF_IRQ_STAT  = 7'h40;
    localparam logic [AW-1:0] OFF_IRQ_MASK  = 7'h44;
    localparam logic [31:0] MAX_CYC_RST = 32'h0003cfb1;
    localparam logic [15:0] MODE_RST    = 16'h0022;
    localparam logic [15:0] MODE_FREE   = 16'h0000;
    localparam logic [15:0] MODE_SYNC0  = 16'h0002;
    localparam logic [15:0] MODE_SYNC1  = 16'h0003;
    localparam logic [15:0] MODE_SM2    = 16'h0022;
    localparam logic [15:0] CMD_START   = 16'h0001;
    localparam logic [15:0] CMD_RST     = 16'h0000;
    localparam logic [3:0]  AL_SAFEOP   = 4'h4;
    localparam logic [3:0]  AL_OP       = 4'h8;
    // clock period in ns, timers advance by this per edge
    localparam logic [31:0] CLK_NS      = 32'h00000004;
    localparam int unsigned IRQ_W       = 4;
    localparam int unsigned IRQ_MISS    = 0;
    localparam int unsigned IRQ_OVER    = 1;
    localparam int unsigned IRQ_SHORT   = 2;
    localparam int unsigned IRQ_LATE    = 3;
    typedef struct packed {
        logic sm2;
        logic sync0;
        logic sync1;
        logic dp_start;
        logic dp_done;
        logic copy_done;
        logic out_driven;
        logic app_overrun;
    } scm_evt_s;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CALC,
        PH_SHIFT,
        PH_OUT
    } scm_phase_e;
endpackage
`default_nettype wire

//--- hdl/scm_top.sv
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module scm_top #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 nrst_i,
    // avalon-mm slave
    input  wire logic [6:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // sync events and state
    input  wire scm_pkg::scm_evt_s    evt_i,
    input  wire logic [3:0]           al_state_i,
    input  wire logic [31:0]          in_delay_ns_i,
    input  wire logic [31:0]          in_calc_ns_i,
    // interrupt
    output logic                      irq_o
);
    if (CNT_W < 2 || CNT_W > 32) begin : g_chk
        $error("CNT_W must lie in 2..32");
    end

    function automatic logic [31:0] sat_add(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[32] ? 32'hffffffff : s[31:0];
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] c
    );
        return (&c) ? c : c + 1'b1;
    endfunction

    function automatic logic [31:0] max32(
        input logic [31:0] a,
        input logic [31:0] b
    );
        return (b > a) ? b : a;
    endfunction

    function automatic logic [31:0] min32(
        input logic [31:0] a,
        input logic [31:0] b
    );
        return (a == 32'h0 || b < a) ? b : a;
    endfunction

    // bus handshake: one wait cycle per access
    logic                       ack;
    logic                       wr;
    logic                       rdc;
    logic [31:0]                rmux;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign wr  = avs_write_i & ack;
    assign rdc = avs_read_i & ack;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
        end
    end

    // software registers
    logic [15:0]                cmd;
    logic [15:0]                mode;
    logic [31:0]                frame_rep;
    logic [scm_pkg::IRQ_W-1:0]  irq_mask;
    logic                       start;
    logic                       meas;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd       <= scm_pkg::CMD_RST;
            mode      <= scm_pkg::MODE_RST;
            frame_rep <= 32'h0;
            irq_mask  <= '0;
        end else if (wr) begin
            unique case (avs_address_i)
                scm_pkg::OFF_CMD:
                    cmd <= avs_writedata_i[15:0];
                scm_pkg::OFF_MODE:
                    mode <= avs_writedata_i[15:0];
                scm_pkg::OFF_FRAME_REP:
                    frame_rep <= avs_writedata_i;
                scm_pkg::OFF_IRQ_MASK:
                    irq_mask <= avs_writedata_i[scm_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    assign start = wr && avs_address_i == scm_pkg::OFF_CMD
                && avs_writedata_i[15:0] == scm_pkg::CMD_START
                && cmd != scm_pkg::CMD_START;
    assign meas = cmd == scm_pkg::CMD_START;

    // mode decode and event roles
    logic                       dc;
    logic                       smm;
    logic                       first;
    logic                       second;
    logic                       calc_end;
    logic                       cyc_end;
    logic                       op;
    logic                       to_op;
    logic [3:0]                 al_prev;
    assign dc  = mode == scm_pkg::MODE_SYNC0
              || mode == scm_pkg::MODE_SYNC1;
    assign smm = mode == scm_pkg::MODE_SM2;
    assign first = (mode == scm_pkg::MODE_SYNC1) ? evt_i.sync0
                 : (smm || mode == scm_pkg::MODE_SYNC0) & evt_i.sm2;
    assign second = (mode == scm_pkg::MODE_SYNC0) ? evt_i.sync0
                  : (mode == scm_pkg::MODE_SYNC1) & evt_i.sync1;
    assign calc_end = smm ? evt_i.dp_start
                    : dc & evt_i.copy_done;
    assign cyc_end = smm ? evt_i.dp_done : dc & evt_i.out_driven;
    assign op = al_state_i == scm_pkg::AL_OP;
    assign to_op = op && al_prev == scm_pkg::AL_SAFEOP;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            al_prev <= 4'h0;
        end else begin
            al_prev <= al_state_i;
        end
    end

    // elapsed-time counters in ns
    logic [31:0]                t_first;
    logic [31:0]                t_second;
    logic                       seen_first;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            t_first    <= 32'h0;
            t_second   <= 32'h0;
            seen_first <= 1'b0;
        end else begin
            t_first  <= first ? scm_pkg::CLK_NS
                      : sat_add(t_first, scm_pkg::CLK_NS);
            t_second <= second ? scm_pkg::CLK_NS
                      : sat_add(t_second, scm_pkg::CLK_NS);
            if (start) begin
                seen_first <= 1'b0;
            end else if (first) begin
                seen_first <= 1'b1;
            end
        end
    end

    // cycle phase
    scm_pkg::scm_phase_e        phase;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= scm_pkg::PH_IDLE;
        end else if (first) begin
            phase <= scm_pkg::PH_CALC;
        end else begin
            unique case (phase)
                scm_pkg::PH_IDLE: ;
                scm_pkg::PH_CALC: begin
                    if (second) begin
                        phase <= scm_pkg::PH_OUT;
                    end else if (calc_end) begin
                        phase <= dc ? scm_pkg::PH_SHIFT
                                    : scm_pkg::PH_OUT;
                    end
                end
                scm_pkg::PH_SHIFT: begin
                    if (second) begin
                        phase <= scm_pkg::PH_OUT;
                    end
                end
                scm_pkg::PH_OUT: begin
                    if (cyc_end) begin
                        phase <= scm_pkg::PH_IDLE;
                    end
                end
            endcase
        end
    end

    logic                       ev_miss;
    logic                       ev_over;
    logic                       ev_short;
    logic                       ev_late;
    logic                       calc_hit;
    logic                       out_hit;
    assign ev_miss  = op & dc & second
                    & phase == scm_pkg::PH_IDLE;
    assign ev_over  = op & first
                    & phase != scm_pkg::PH_IDLE;
    assign ev_short = second & phase == scm_pkg::PH_CALC;
    assign ev_late  = dc & first & phase == scm_pkg::PH_OUT;
    assign calc_hit = calc_end & phase == scm_pkg::PH_CALC & ~first;
    assign out_hit  = dc & cyc_end & phase == scm_pkg::PH_OUT & ~first;

    // held maxima and minima, cleared at each start
    logic [31:0]                max_cyc;
    logic [31:0]                calc_copy;
    logic [31:0]                out_dly;
    logic [31:0]                min_cd;
    logic [31:0]                max_cd;
    logic [31:0]                min_sd;
    logic [31:0]                max_sd;
    logic [31:0]                cyc_sum;
    assign cyc_sum = sat_add(sat_add(t_first, in_delay_ns_i),
                             in_calc_ns_i);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            max_cyc   <= scm_pkg::MAX_CYC_RST;
            calc_copy <= 32'h0;
            out_dly   <= 32'h0;
        end else if (start) begin
            max_cyc   <= 32'h0;
            calc_copy <= 32'h0;
            out_dly   <= 32'h0;
        end else if (meas) begin
            if (calc_hit) begin
                max_cyc   <= max32(max_cyc, cyc_sum);
                calc_copy <= max32(calc_copy, t_first);
            end
            if (out_hit) begin
                out_dly <= max32(out_dly, t_second);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            min_cd <= 32'h0;
            max_cd <= 32'h0;
            min_sd <= 32'h0;
            max_sd <= 32'h0;
        end else if (start) begin
            min_cd <= 32'h0;
            max_cd <= 32'h0;
            min_sd <= 32'h0;
            max_sd <= 32'h0;
        end else if (meas) begin
            if (first && seen_first) begin
                min_cd <= min32(min_cd, t_first);
                max_cd <= max32(max_cd, t_first);
            end
            if (second && (phase == scm_pkg::PH_CALC
                        || phase == scm_pkg::PH_SHIFT)) begin
                min_sd <= min32(min_sd, t_first);
                max_sd <= max32(max_sd, t_first);
            end
        end
    end

    // saturating event counters
    logic [CNT_W-1:0]           missed_cnt;
    logic [CNT_W-1:0]           over_cnt;
    logic [CNT_W-1:0]           short_cnt;
    logic [CNT_W-1:0]           app_cnt;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            missed_cnt <= '0;
            over_cnt   <= '0;
            short_cnt  <= '0;
            app_cnt    <= '0;
        end else if (to_op) begin
            missed_cnt <= '0;
            over_cnt   <= '0;
            short_cnt  <= '0;
            app_cnt    <= '0;
        end else begin
            if (ev_miss) begin
                missed_cnt <= sat_inc(missed_cnt);
            end
            if (ev_over) begin
                over_cnt <= sat_inc(over_cnt);
            end
            if (ev_short) begin
                short_cnt <= sat_inc(short_cnt);
            end
            if (op && evt_i.app_overrun) begin
                app_cnt <= sat_inc(app_cnt);
            end
        end
    end

    // late-output flag reflects the last DC cycle
    logic                       late;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            late <= 1'b0;
        end else if (dc && first) begin
            late <= phase == scm_pkg::PH_OUT;
        end else if (!dc) begin
            late <= 1'b0;
        end
    end

    // sticky status, cleared by read, set wins
    logic [scm_pkg::IRQ_W-1:0]  irq_stat;
    logic [scm_pkg::IRQ_W-1:0]  irq_set;
    logic                       stat_clr;
    logic [scm_pkg::IRQ_W-1:0]  clr_bits;
    assign irq_set = {ev_late, ev_short, ev_over, ev_miss};
    assign stat_clr = rdc && avs_address_i == scm_pkg::OFF_IRQ_STAT;
    // clear only what the read returned, so a bit set in the wait cycle
    // survives to the next read
    assign clr_bits = stat_clr ? avs_readdata_o[scm_pkg::IRQ_W-1:0] : '0;
    assign irq_o = |(irq_stat & irq_mask);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~clr_bits) | irq_set;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rmux = 32'h0;
        unique case (avs_address_i)
            scm_pkg::OFF_MAX_CYC:   rmux = max_cyc;
            scm_pkg::OFF_CALC_COPY: rmux = calc_copy;
            scm_pkg::OFF_MIN_DLY:   rmux = 32'h0;
            scm_pkg::OFF_CMD:       rmux = {16'h0, cmd};
            scm_pkg::OFF_OUT_DLY:   rmux = out_dly;
            scm_pkg::OFF_MISSED:    rmux = 32'(missed_cnt);
            scm_pkg::OFF_OVERRUN:   rmux = 32'(over_cnt);
            scm_pkg::OFF_SHORT:     rmux = 32'(short_cnt);
            scm_pkg::OFF_MIN_CD:    rmux = min_cd;
            scm_pkg::OFF_MAX_CD:    rmux = max_cd;
            scm_pkg::OFF_MIN_SD:    rmux = min_sd;
            scm_pkg::OFF_MAX_SD:    rmux = max_sd;
            scm_pkg::OFF_APP_OV:    rmux = 32'(app_cnt);
            scm_pkg::OFF_FRAME_REP: rmux = frame_rep;
            scm_pkg::OFF_LATE:      rmux = {31'h0, late};
            scm_pkg::OFF_MODE:      rmux = {16'h0, mode};
            scm_pkg::OFF_IRQ_STAT:  rmux = 32'(irq_stat);
            scm_pkg::OFF_IRQ_MASK:  rmux = 32'(irq_mask);
            default:                rmux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= rmux;
        end
    end

    // checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_cmd_wr;
        wr && avs_address_i == scm_pkg::OFF_CMD;
    endsequence

    sequence s_calc_meas;
        meas && !start && calc_hit;
    endsequence

    property p_cmd_store;
        s_cmd_wr |=> cmd == $past(avs_writedata_i[15:0]);
    endproperty
    a_cmd_store: assert property (p_cmd_store)
        else $error("command not stored");

    property p_cyc_sum;
        s_calc_meas |=> max_cyc >= $past(cyc_sum)
                     && calc_copy >= $past(t_first);
    endproperty
    a_cyc_sum: assert property (p_cyc_sum)
        else $error("max cycle below measured sum");

    property p_hold_max;
        meas && !start |=> max_cyc >= $past(max_cyc)
                        && out_dly >= $past(out_dly);
    endproperty
    a_hold_max: assert property (p_hold_max)
        else $error("held maximum dropped");

    property p_start_clr;
        start |=> max_cyc == 32'h0 && calc_copy == 32'h0
              && out_dly == 32'h0;
    endproperty
    a_start_clr: assert property (p_start_clr)
        else $error("maxima not cleared on start");

    property p_dly_dc;
        !dc && !start |=> $stable(out_dly);
    endproperty
    a_dly_dc: assert property (p_dly_dc)
        else $error("delay moved outside DC mode");

    property p_miss_inc;
        ev_miss && !to_op && !(&missed_cnt)
            |=> missed_cnt == $past(missed_cnt) + 1'b1;
    endproperty
    a_miss_inc: assert property (p_miss_inc)
        else $error("missed counter did not count");

    property p_op_clr;
        to_op |=> missed_cnt == '0 && over_cnt == '0
              && short_cnt == '0;
    endproperty
    a_op_clr: assert property (p_op_clr)
        else $error("counters not cleared entering OP");

    property p_over_inc;
        ev_over && !to_op && !(&over_cnt)
            |=> over_cnt == $past(over_cnt) + 1'b1;
    endproperty
    a_over_inc: assert property (p_over_inc)
        else $error("overrun counter did not count");

    property p_short_inc;
        ev_short && !to_op && !(&short_cnt)
            |=> short_cnt == $past(short_cnt) + 1'b1;
    endproperty
    a_short_inc: assert property (p_short_inc)
        else $error("short shift counter did not count");

    property p_late;
        dc && first && phase == scm_pkg::PH_OUT
            |=> late && irq_stat[scm_pkg::IRQ_LATE];
    endproperty
    a_late: assert property (p_late)
        else $error("late outputs not flagged");

    property p_sat;
        &over_cnt && !to_op |=> &over_cnt;
    endproperty
    a_sat: assert property (p_sat)
        else $error("overrun counter wrapped");
endmodule
`default_nettype wire

//--- tb/scm_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module scm_master_model (
    // clock
    input  wire logic         mclk_i,
    // events and state
    output scm_pkg::scm_evt_s evt_o,
    output logic [3:0]        al_state_o,
    output logic [31:0]       in_delay_ns_o,
    output logic [31:0]       in_calc_ns_o
);
    initial begin
        evt_o         = '0;
        al_state_o    = scm_pkg::AL_SAFEOP;
        in_delay_ns_o = 32'h00000064;
        in_calc_ns_o  = 32'h0000003c;
    end

    // one-cycle pulse, next event d cycles later; callers pick d
    // for each event
    task automatic ev(input scm_pkg::scm_evt_s e, input int d);
        evt_o <= e;
        @(posedge mclk_i);
        evt_o <= '0;
        repeat (d - 1) @(posedge mclk_i);
    endtask

    task automatic set_state(input logic [3:0] s);
        al_state_o <= s;
        @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

//--- tb/scm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module scm_tb_top;
    localparam scm_pkg::scm_evt_s SM2 = 8'h80;
    localparam scm_pkg::scm_evt_s S0  = 8'h40;
    localparam scm_pkg::scm_evt_s S1  = 8'h20;
    localparam scm_pkg::scm_evt_s DPS = 8'h10;
    localparam scm_pkg::scm_evt_s DPD = 8'h08;
    localparam scm_pkg::scm_evt_s CPY = 8'h04;
    localparam scm_pkg::scm_evt_s OUT = 8'h02;
    logic              mclk;
    logic              nrst;
    logic [6:0]        addr;
    logic              rd;
    logic              wr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic              wait_req;
    logic              irq;
    scm_pkg::scm_evt_s evt;
    logic [3:0]        al_state;
    logic [31:0]       in_dly;
    logic [31:0]       in_calc;
    logic [31:0]       q;
    logic [15:0]       modes [4];
    int                errors;
    int                n_checks;

    // two-bit counters so saturation is reached quickly
    scm_top #(.CNT_W(2)) dut_u (
        .mclk_i           (mclk),
        .nrst_i           (nrst),
        .avs_address_i    (addr),
        .avs_read_i       (rd),
        .avs_write_i      (wr),
        .avs_writedata_i  (wdata),
        .avs_readdata_o   (rdata),
        .avs_waitrequest_o(wait_req),
        .evt_i            (evt),
        .al_state_i       (al_state),
        .in_delay_ns_i    (in_dly),
        .in_calc_ns_i     (in_calc),
        .irq_o            (irq)
    );

    scm_master_model mst_u (
        .mclk_i       (mclk),
        .evt_o        (evt),
        .al_state_o   (al_state),
        .in_delay_ns_o(in_dly),
        .in_calc_ns_o (in_calc)
    );

    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge;
    // data taken and request dropped at that same edge
    task automatic bus(input logic w, input logic [6:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge mclk);
        end while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic irqc(input logic exp);
        @(posedge mclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
        errors = 0;
        n_checks = 0;
        modes = '{16'h0000, 16'h0002, 16'h0003, 16'h0022};
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rdc(scm_pkg::OFF_MAX_CYC, scm_pkg::MAX_CYC_RST);
        rdc(scm_pkg::OFF_CMD, 32'h0);
        rdc(scm_pkg::OFF_LATE, 32'h0);
        rdc(scm_pkg::OFF_MODE, 32'h00000022);
        rdc(7'h50, 32'h0);
        bus(1'b1, scm_pkg::OFF_MAX_CYC, 32'hffffffff);
        rdc(scm_pkg::OFF_MAX_CYC, scm_pkg::MAX_CYC_RST);
        foreach (modes[i]) begin
            bus(1'b1, scm_pkg::OFF_MODE, {16'h0, modes[i]});
            rdc(scm_pkg::OFF_MODE, {16'h0, modes[i]});
        end
        mst_u.set_state(scm_pkg::AL_OP);
        // sync0 mode cycle under measurement
        bus(1'b1, scm_pkg::OFF_MODE, 32'h2);
        bus(1'b1, scm_pkg::OFF_CMD, 32'h1);
        rdc(scm_pkg::OFF_MAX_CYC, 32'h0);
        rdc(scm_pkg::OFF_CMD, 32'h1);
        mst_u.ev(SM2, 10);
        mst_u.ev(CPY, 10);
        mst_u.ev(S0, 5);
        mst_u.ev(OUT, 10);
        rdc(scm_pkg::OFF_CALC_COPY, 32'h28);
        rdc(scm_pkg::OFF_MAX_CYC, 32'hc8);
        rdc(scm_pkg::OFF_OUT_DLY, 32'h14);
        rdc(scm_pkg::OFF_MISSED, 32'h0);
        rdc(scm_pkg::OFF_OVERRUN, 32'h0);
        // sync1 mode: longer delay, shorter calc
        bus(1'b1, scm_pkg::OFF_MODE, 32'h3);
        mst_u.ev(S0, 3);
        mst_u.ev(CPY, 3);
        mst_u.ev(S1, 7);
        mst_u.ev(OUT, 10);
        rdc(scm_pkg::OFF_OUT_DLY, 32'h1c);
        rdc(scm_pkg::OFF_CALC_COPY, 32'h28);
        rdc(scm_pkg::OFF_MAX_SD, 32'h50);
        rdc(scm_pkg::OFF_MIN_SD, 32'h18);
        bus(1'b1, scm_pkg::OFF_FRAME_REP, 32'h12345678);
        rdc(scm_pkg::OFF_FRAME_REP, 32'h12345678);
        // stopped: a longer calc is not recorded
        bus(1'b1, scm_pkg::OFF_CMD, 32'h0);
        bus(1'b1, scm_pkg::OFF_MODE, 32'h2);
        mst_u.ev(SM2, 20);
        mst_u.ev(CPY, 5);
        mst_u.ev(S0, 5);
        mst_u.ev(OUT, 10);
        rdc(scm_pkg::OFF_CALC_COPY, 32'h28);
        // restart in sm2 mode
        bus(1'b1, scm_pkg::OFF_MODE, 32'h22);
        bus(1'b1, scm_pkg::OFF_CMD, 32'h1);
        rdc(scm_pkg::OFF_CALC_COPY, 32'h0);
        mst_u.ev(SM2, 5);
        mst_u.ev(DPS, 5);
        mst_u.ev(DPD, 10);
        rdc(scm_pkg::OFF_CALC_COPY, 32'h14);
        // second events without a first: missed, saturating
        bus(1'b1, scm_pkg::OFF_MODE, 32'h2);
        repeat (4) mst_u.ev(S0, 4);
        rdc(scm_pkg::OFF_MISSED, 32'h3);
        irqc(1'b0);
        bus(1'b1, scm_pkg::OFF_IRQ_MASK, 32'h1);
        irqc(1'b1);
        bus(1'b0, scm_pkg::OFF_IRQ_STAT, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        irqc(1'b0);
        mst_u.set_state(scm_pkg::AL_SAFEOP);
        mst_u.set_state(scm_pkg::AL_OP);
        rdc(scm_pkg::OFF_MISSED, 32'h0);
        // short shift, overrun and late outputs
        mst_u.ev(SM2, 3);
        mst_u.ev(S0, 3);
        mst_u.ev(SM2, 3);
        rdc(scm_pkg::OFF_SHORT, 32'h1);
        rdc(scm_pkg::OFF_OVERRUN, 32'h1);
        rdc(scm_pkg::OFF_LATE, 32'h1);
        mst_u.ev(CPY, 3);
        mst_u.ev(S0, 3);
        mst_u.ev(OUT, 3);
        mst_u.ev(SM2, 3);
        rdc(scm_pkg::OFF_LATE, 32'h0);
        mst_u.set_state(scm_pkg::AL_SAFEOP);
        mst_u.set_state(scm_pkg::AL_OP);
        rdc(scm_pkg::OFF_OVERRUN, 32'h0);
        rdc(scm_pkg::OFF_SHORT, 32'h0);
        // master has lengthened cycle and shift: nothing more is counted
        repeat (2) begin
            mst_u.ev(CPY, 10);
            mst_u.ev(S0, 5);
            mst_u.ev(OUT, 10);
            mst_u.ev(SM2, 10);
        end
        rdc(scm_pkg::OFF_OVERRUN, 32'h0);
        rdc(scm_pkg::OFF_SHORT, 32'h0);
        rdc(scm_pkg::OFF_MISSED, 32'h0);
        rdc(scm_pkg::OFF_LATE, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
